// [cwu_pkg.sv]
// Constants and types for the option words and stop-mode wakeup block.
//
// Functional notes
// - Wakeup generator starts at stop entry when wakeup interrupt enable is set.
// - Wakeup counters restart from zero on every stop entry.
// - Shared mask set suppresses the keypad/wakeup interrupt, not the latch; reset clears the mask.
// - Wakeup latch reads as a read-only bit of port A data.
// - Status/control bits 7 to 4 read zero and ignore writes.
// - Shared flag is set while a keypad/wakeup request is pending; reset clears.
// - Writing one to acknowledge clears the pending request; it reads zero.
// - Wakeup interrupt enable gates latching of wakeup requests; reset clears.
// - Each option word takes one write per reset; reads always allowed.
// - Option words decode at addresses 001e and 001f.
// - Pullup-off bit disconnects the interrupt pin pullup when one.
// - Pin function bits activate the interrupt or reset pin function when one.
// - Two-bit field selects internal, external, external RC or crystal clock.
// - Reset-pin function and detector voltage mode clear only at power-on.
// - Outside stop, period select gives 8176 or 262128 cycle watchdog timeout.
// - In stop, period select gives 512 or 16384 wakeup oscillator cycles.
// - Detector runs in stop when its stop enable is set and power is on.
// - Detector reset-off, power-off and 5 V or 3 V mode bits steer detector.
// - Short recovery bit gives 32 or 4096 cycle stop exit delay.
// - Stop exit by detector reset always uses the long recovery delay.
// - Stop enable permits stop; otherwise stop is an illegal opcode.
// - Watchdog-off bit disables the watchdog module when one.
// - Counter overflow latches a wakeup request for the keypad logic.
// - Wakeup latch sits at bit 6 of port A data.
// - Wakeup oscillator and counters run only in stop mode.
package cwu_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [15:0] CWU_ADDR_PORTA = 16'h0000;
    localparam logic [15:0] CWU_ADDR_KSC   = 16'h001a;
    localparam logic [15:0] CWU_ADDR_KEN   = 16'h001b;
    localparam logic [15:0] CWU_ADDR_OPT2  = 16'h001e;
    localparam logic [15:0] CWU_ADDR_OPT1  = 16'h001f;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CWU_PA_LATCH   = 6;
    localparam int CWU_KSC_FLAG   = 3;
    localparam int CWU_KSC_ACK    = 2;
    localparam int CWU_KSC_MASK   = 1;
    localparam int CWU_KEN_WIE    = 6;
    localparam int CWU_O2_PUOFF   = 7;
    localparam int CWU_O2_IRQON   = 6;
    localparam int CWU_O2_CSHI    = 4;
    localparam int CWU_O2_CSLO    = 3;
    localparam int CWU_O2_RSTON   = 0;
    localparam int CWU_O1_PSEL    = 7;
    localparam int CWU_O1_DSTOP   = 6;
    localparam int CWU_O1_DRSTOFF = 5;
    localparam int CWU_O1_DPWROFF = 4;
    localparam int CWU_O1_DVMODE  = 3;
    localparam int CWU_O1_SHORT_STOP_RECOVERY   = 2;
    localparam int CWU_O1_STOPEN  = 1;
    localparam int CWU_O1_WDOFF   = 0;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] CWU_OPT_RST = 8'h00;
    localparam logic [7:0] CWU_ZERO8   = 8'h00;

    // ****************************************************************
    // Cycle counts
    // ****************************************************************
    localparam logic [17:0] CWU_WD_SHORT  = 18'd8176;
    localparam logic [17:0] CWU_WD_LONG   = 18'd262128;
    localparam logic [14:0] CWU_WK_SHORT  = 15'd512;
    localparam int          CWU_WK_LONG   = 16384;
    localparam int          CWU_OSC_DIV   = 8;
    localparam logic [12:0] CWU_REC_SHORT = 13'd32;
    localparam logic [12:0] CWU_REC_LONG  = 13'd4096;

    typedef enum logic [1:0] {
        CWU_RUN   = 2'b00,
        CWU_STOP  = 2'b01,
        CWU_RECOV = 2'b11
    } cwu_mode_t;

    typedef enum logic [1:0] {
        CWU_CS_INT  = 2'b00,
        CWU_CS_EXT  = 2'b01,
        CWU_CS_RC   = 2'b10,
        CWU_CS_XTAL = 2'b11
    } cwu_clksrc_t;

endpackage : cwu_pkg

// [cwu_wake_if.sv]
// Link between the control block and the wakeup period generator.
`timescale 1ns/100ps
`default_nettype none
interface cwu_wake_if;
    logic run;
    logic short_sel;
    logic req;
    modport ctl (output run, output short_sel, input req);
    modport gen (input run, input short_sel, output req);
endinterface : cwu_wake_if
`default_nettype wire

// [cwu_wake_gen.sv]
// Periodic wakeup generator running only while stop mode is held.
`timescale 1ns/100ps
`default_nettype none
module cwu_wake_gen #(
    parameter int LONG_CNT = 16384,
    parameter int OSC_DIV  = 8
) (
    input  wire logic  sys_clk_in,
    input  wire logic  nrst_in,
    cwu_wake_if.gen    wk
);
    import cwu_pkg::*;

    logic [15:0] div_r;
    logic [14:0] cnt_r;
    logic        tick;
    logic [14:0] limit;

    assign tick  = (div_r == 16'(OSC_DIV - 1));
    assign limit = wk.short_sel ? CWU_WK_SHORT : 15'(LONG_CNT);

    // ****************************************************************
    // Oscillator stand-in divider
    // ****************************************************************
    // Held at zero outside stop so every stop entry starts afresh.
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in || !wk.run) begin
            div_r <= 16'h0000;
        end else if (tick) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    // ****************************************************************
    // Period counter
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in || !wk.run) begin
            cnt_r <= 15'h0000;
            wk.req <= 1'b0;
        end else if (tick && cnt_r == limit - 15'h0001) begin
            cnt_r <= 15'h0000;
            wk.req <= 1'b1;
        end else begin
            if (tick) begin
                cnt_r <= cnt_r + 15'h0001;
            end
            wk.req <= 1'b0;
        end
    end

endmodule : cwu_wake_gen
`default_nettype wire

// [cwu_top.sv]
// Option words, keypad/wakeup status and stop-mode sequencing.
`timescale 1ns/100ps
`default_nettype none
module cwu_top #(
    parameter int WAKE_LONG_CNT = 16384,
    parameter int WAKE_OSC_DIV  = 8
) (
    input  wire logic        sys_clk_in,
    input  wire logic        nrst_in,
    input  wire logic        por_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output var  logic [7:0]  rdata_out,
    input  wire logic        stop_req_in,
    input  wire logic        lvi_rst_in,
    output var  logic        stop_mode_out,
    output var  logic        illegal_op_out,
    output var  logic        irq_out,
    output var  logic        irq_pullup_off_out,
    output var  logic        irq_pin_on_out,
    output var  logic        reset_pin_on_out,
    output var  cwu_pkg::cwu_clksrc_t clk_src_out,
    output var  logic [17:0] wd_timeout_out,
    output var  logic        wd_off_out,
    output var  logic        det_run_out,
    output var  logic        det_reset_off_out,
    output var  logic        det_5v_out,
    output var  logic [12:0] recovery_out
);
    import cwu_pkg::*;

    cwu_wake_if wk ();

    cwu_wake_gen #(
        .LONG_CNT (WAKE_LONG_CNT),
        .OSC_DIV  (WAKE_OSC_DIV)
    ) u_gen (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .wk         (wk)
    );

    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] off);
        hit = (a == off);
    endfunction : hit

    logic [7:0]  opt1_r;
    logic [7:0]  opt2_r;
    logic        opt1_done_r;
    logic        opt2_done_r;
    logic        rst_pin_r;
    logic        dvmode_r;
    logic        mask_r;
    logic        wie_r;
    logic        latch_r;
    cwu_mode_t   mode_r;
    logic [12:0] rec_cnt_r;
    logic        rst_any;
    logic        wr_o1;
    logic        wr_o2;
    logic        ack;
    logic        wake_irq;

    assign rst_any = !nrst_in || por_in;
    // A write seen while reset is held must not reach the power-on-only bits.
    assign wr_o1   = !rst_any && wr_in && hit(addr_in, CWU_ADDR_OPT1) && !opt1_done_r;
    assign wr_o2   = !rst_any && wr_in && hit(addr_in, CWU_ADDR_OPT2) && !opt2_done_r;
    assign ack     = wr_in && hit(addr_in, CWU_ADDR_KSC) && wdata_in[CWU_KSC_ACK];
    assign wake_irq = latch_r && !mask_r;

    // ****************************************************************
    // Option words
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_any) begin
            opt1_r      <= CWU_OPT_RST;
            opt2_r      <= CWU_OPT_RST;
            opt1_done_r <= 1'b0;
            opt2_done_r <= 1'b0;
        end else begin
            if (wr_o1) begin
                opt1_r      <= wdata_in;
                opt1_done_r <= 1'b1;
            end
            if (wr_o2) begin
                opt2_r      <= wdata_in;
                opt2_done_r <= 1'b1;
            end
        end
    end

    // Bits that only power-on reset clears.
    always_ff @(posedge sys_clk_in) begin
        if (por_in) begin
            rst_pin_r <= 1'b0;
            dvmode_r  <= 1'b0;
        end else begin
            if (wr_o2) begin
                rst_pin_r <= wdata_in[CWU_O2_RSTON];
            end
            if (wr_o1) begin
                dvmode_r <= wdata_in[CWU_O1_DVMODE];
            end
        end
    end

    // ****************************************************************
    // Keypad/wakeup control
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_any) begin
            mask_r <= 1'b0;
            wie_r  <= 1'b0;
        end else begin
            if (wr_in && hit(addr_in, CWU_ADDR_KSC)) begin
                mask_r <= wdata_in[CWU_KSC_MASK];
            end
            if (wr_in && hit(addr_in, CWU_ADDR_KEN)) begin
                wie_r <= wdata_in[CWU_KEN_WIE];
            end
        end
    end

    // A request arriving with the acknowledge wins over the clear.
    always_ff @(posedge sys_clk_in) begin
        if (rst_any) begin
            latch_r <= 1'b0;
        end else if (wk.req && wie_r) begin
            latch_r <= 1'b1;
        end else if (ack) begin
            latch_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Stop mode sequencing
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_any) begin
            mode_r    <= CWU_RUN;
            rec_cnt_r <= CWU_REC_LONG;
        end else begin
            case (mode_r)
                CWU_RUN: begin
                    if (stop_req_in && opt1_r[CWU_O1_STOPEN]) begin
                        mode_r <= CWU_STOP;
                    end
                end
                CWU_STOP: begin
                    if (lvi_rst_in) begin
                        mode_r    <= CWU_RECOV;
                        rec_cnt_r <= CWU_REC_LONG;
                    end else if (wake_irq) begin
                        mode_r    <= CWU_RECOV;
                        rec_cnt_r <= opt1_r[CWU_O1_SHORT_STOP_RECOVERY] ?
                                     CWU_REC_SHORT : CWU_REC_LONG;
                    end
                end
                CWU_RECOV: begin
                    if (rec_cnt_r == 13'h0001) begin
                        mode_r <= CWU_RUN;
                    end else begin
                        rec_cnt_r <= rec_cnt_r - 13'h0001;
                    end
                end
                default: begin
                    mode_r <= CWU_RUN;
                end
            endcase
        end
    end

    // Generator runs only in stop and only when the wakeup is enabled.
    assign wk.run       = (mode_r == CWU_STOP) && wie_r;
    assign wk.short_sel = opt1_r[CWU_O1_PSEL];

    // ****************************************************************
    // Status and option outputs
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_any) begin
            stop_mode_out  <= 1'b0;
            illegal_op_out <= 1'b0;
            irq_out        <= 1'b0;
            recovery_out   <= CWU_REC_LONG;
        end else begin
            stop_mode_out  <= (mode_r == CWU_STOP);
            illegal_op_out <= (mode_r == CWU_RUN) && stop_req_in &&
                              !opt1_r[CWU_O1_STOPEN];
            irq_out        <= wake_irq;
            recovery_out   <= opt1_r[CWU_O1_SHORT_STOP_RECOVERY] ?
                              CWU_REC_SHORT : CWU_REC_LONG;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_any) begin
            irq_pullup_off_out <= 1'b0;
            irq_pin_on_out     <= 1'b0;
            clk_src_out        <= CWU_CS_INT;
            wd_timeout_out     <= CWU_WD_LONG;
            wd_off_out         <= 1'b0;
            det_run_out        <= 1'b0;
            det_reset_off_out  <= 1'b0;
        end else begin
            irq_pullup_off_out <= opt2_r[CWU_O2_PUOFF];
            irq_pin_on_out     <= opt2_r[CWU_O2_IRQON];
            clk_src_out        <= cwu_clksrc_t'({opt2_r[CWU_O2_CSHI],
                                                 opt2_r[CWU_O2_CSLO]});
            wd_timeout_out     <= opt1_r[CWU_O1_PSEL] ?
                                  CWU_WD_SHORT : CWU_WD_LONG;
            wd_off_out         <= opt1_r[CWU_O1_WDOFF];
            det_run_out        <= !opt1_r[CWU_O1_DPWROFF] &&
                                  ((mode_r != CWU_STOP) ||
                                   opt1_r[CWU_O1_DSTOP]);
            det_reset_off_out  <= opt1_r[CWU_O1_DRSTOFF];
        end
    end

    // Power-on-only bits feed these, so they follow por_in alone.
    always_ff @(posedge sys_clk_in) begin
        if (por_in) begin
            reset_pin_on_out <= 1'b0;
            det_5v_out       <= 1'b0;
        end else begin
            reset_pin_on_out <= rst_pin_r;
            det_5v_out       <= dvmode_r;
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_any) begin
            rdata_out <= CWU_ZERO8;
        end else if (rd_in) begin
            rdata_out <= CWU_ZERO8;
            if (hit(addr_in, CWU_ADDR_PORTA)) begin
                rdata_out[CWU_PA_LATCH] <= latch_r;
            end
            if (hit(addr_in, CWU_ADDR_KSC)) begin
                rdata_out[CWU_KSC_FLAG] <= latch_r;
                rdata_out[CWU_KSC_MASK] <= mask_r;
            end
            if (hit(addr_in, CWU_ADDR_KEN)) begin
                rdata_out[CWU_KEN_WIE] <= wie_r;
            end
            if (hit(addr_in, CWU_ADDR_OPT1)) begin
                rdata_out <= {opt1_r[7:4], dvmode_r, opt1_r[2:0]};
            end
            if (hit(addr_in, CWU_ADDR_OPT2)) begin
                rdata_out <= {opt2_r[7:1], rst_pin_r};
            end
        end else begin
            rdata_out <= CWU_ZERO8;
        end
    end

endmodule : cwu_top
`default_nettype wire

// [cwu_top_properties.sv]
// Port checks for the option words and stop-mode wakeup block.
`timescale 1ns/100ps
`default_nettype none
module cwu_top_properties #(
    parameter int WAKE_LONG_CNT = 16384,
    parameter int WAKE_OSC_DIV  = 8
) (
    input  wire logic        sys_clk_in,
    input  wire logic        nrst_in,
    input  wire logic        por_in,
    input  wire logic        rd_in,
    input  wire logic        stop_req_in,
    input  wire logic [7:0]  rdata_out,
    input  wire logic        stop_mode_out,
    input  wire logic        illegal_op_out,
    input  wire logic        irq_out,
    input  wire logic [17:0] wd_timeout_out,
    input  wire logic [12:0] recovery_out
);
    // ********************************
    // Assertions
    // ********************************
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in || por_in);
    a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data not zero outside read slot");
    a_wd_map: assert property (wd_timeout_out == 18'h01ff0 || wd_timeout_out == 18'h3fff0)
        else $error("watchdog timeout off the two choices");
    a_rec_map: assert property (recovery_out == 13'h0020 || recovery_out == 13'h1000)
        else $error("recovery count off the two choices");
    a_stop_entry: assert property ($rose(stop_mode_out) |-> $past(stop_req_in, 2) || $past(stop_req_in, 3))
        else $error("stop mode entered without request");
    a_illegal_cause: assert property (illegal_op_out |-> $past(stop_req_in) || $past(stop_req_in, 2))
        else $error("illegal opcode flag without stop request");
    a_illegal_run: assert property (illegal_op_out |-> !stop_mode_out)
        else $error("refused stop request entered stop");
    a_irq_exit: assert property ($rose(irq_out) && stop_mode_out |-> ##[0:2] !stop_mode_out)
        else $error("wakeup interrupt did not leave stop");
    a_wake_min: assert property ($rose(stop_mode_out) && !irq_out |=> !irq_out [*8])
        else $error("wakeup came too soon after stop entry");
    a_reset_vals: assert property ($rose(nrst_in) |-> wd_timeout_out == 18'h3fff0 && recovery_out == 13'h1000 && !irq_out)
        else $error("outputs not at reset values");
    c_wake: cover property ($rose(irq_out));
    c_illegal: cover property (illegal_op_out);
    c_stop: cover property ($rose(stop_mode_out));
endmodule : cwu_top_properties
bind cwu_top cwu_top_properties #(.WAKE_LONG_CNT(WAKE_LONG_CNT), .WAKE_OSC_DIV(WAKE_OSC_DIV)) u_props (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .por_in(por_in), .rd_in(rd_in),
    .stop_req_in(stop_req_in), .rdata_out(rdata_out), .stop_mode_out(stop_mode_out),
    .illegal_op_out(illegal_op_out), .irq_out(irq_out), .wd_timeout_out(wd_timeout_out),
    .recovery_out(recovery_out));
`default_nettype wire

// [cwu_top_tb.sv]
// Self-checking bench for the option words and stop-mode wakeup block.
`timescale 1ns/100ps
`default_nettype none
module cwu_top_tb;
    import cwu_pkg::*;
    localparam int LCNT = 64;
    localparam int DIV  = 2;
    logic        sys_clk_in, nrst_in, por_in, wr_in, rd_in, stop_req_in, lvi_rst_in;
    logic [15:0] addr_in;
    logic [7:0]  wdata_in, rdata_out;
    logic        stop_mode_out, illegal_op_out, irq_out, irq_pullup_off_out, irq_pin_on_out;
    logic        reset_pin_on_out, wd_off_out, det_run_out, det_reset_off_out, det_5v_out;
    cwu_clksrc_t clk_src_out;
    logic [17:0] wd_timeout_out;
    logic [12:0] recovery_out;
    int          n_mismatch = 0;
    int          n_checks   = 0;

    cwu_top #(.WAKE_LONG_CNT(LCNT), .WAKE_OSC_DIV(DIV)) u_cwu_top (
        .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .por_in(por_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .stop_req_in(stop_req_in), .lvi_rst_in(lvi_rst_in), .stop_mode_out(stop_mode_out),
        .illegal_op_out(illegal_op_out), .irq_out(irq_out),
        .irq_pullup_off_out(irq_pullup_off_out), .irq_pin_on_out(irq_pin_on_out),
        .reset_pin_on_out(reset_pin_on_out), .clk_src_out(clk_src_out),
        .wd_timeout_out(wd_timeout_out), .wd_off_out(wd_off_out), .det_run_out(det_run_out),
        .det_reset_off_out(det_reset_off_out), .det_5v_out(det_5v_out),
        .recovery_out(recovery_out));

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    // ********************************
    // Bus and helper tasks
    // ********************************
    task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Waits end on a falling edge so that checks see settled outputs.
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : tick

    task automatic do_reset(input logic por);
        @(posedge sys_clk_in);
        nrst_in <= 1'b0;
        por_in  <= por;
        repeat (5) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        por_in  <= 1'b0;
        tick(1);
    endtask : do_reset

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        tick(1);
        chk("rdata", 18'(rdata_out), 18'(exp));
    endtask : rd

    task automatic pulse_stop(input logic low_voltage_detector);
        @(posedge sys_clk_in);
        stop_req_in <= !low_voltage_detector;
        lvi_rst_in  <= low_voltage_detector;
        @(posedge sys_clk_in);
        stop_req_in <= 1'b0;
        lvi_rst_in  <= 1'b0;
    endtask : pulse_stop

    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_reset_vals();
        do_reset(1'b1);
        chk("wd_timeout", wd_timeout_out, 18'h3fff0);
        chk("recovery", 18'(recovery_out), 18'h01000);
        rd(CWU_ADDR_KEN, 8'h00);
        rd(16'h0005, 8'h00);
        wr(CWU_ADDR_KSC, 8'hff);
        rd(CWU_ADDR_KSC, 8'h02);
        wr(CWU_ADDR_KSC, 8'h00);
        rd(CWU_ADDR_KSC, 8'h00);
    endtask : t_reset_vals

    task automatic t_clk_src();
        for (int i = 0; i < 4; i++) begin
            do_reset(1'b0);
            wr(CWU_ADDR_OPT2, (8'(i) << 3) | ((i == 3) ? 8'hc1 : 8'h00));
            tick(2);
            chk("clk_src", 18'(clk_src_out), 18'(i));
        end
        chk("pullup_off", 18'(irq_pullup_off_out), 18'h1);
        chk("irq_pin", 18'(irq_pin_on_out), 18'h1);
        wr(CWU_ADDR_OPT2, 8'h00);
        rd(CWU_ADDR_OPT2, 8'hd9);
        do_reset(1'b0);
        chk("rst_pin", 18'(reset_pin_on_out), 18'h1);
        do_reset(1'b1);
        chk("rst_pin", 18'(reset_pin_on_out), 18'h0);
    endtask : t_clk_src

    task automatic t_opt1();
        wr(CWU_ADDR_OPT1, 8'h19);
        wr(CWU_ADDR_OPT1, 8'he6);
        rd(CWU_ADDR_OPT1, 8'h19);
        chk("wd_off", 18'(wd_off_out), 18'h1);
        chk("det", 18'({det_run_out, det_reset_off_out, det_5v_out}), 18'h1);
        pulse_stop(1'b0);
        tick(1);
        chk("illegal", 18'(illegal_op_out), 18'h1);
        do_reset(1'b0);
        chk("det_5v", 18'(det_5v_out), 18'h1);
        wr(CWU_ADDR_OPT1, 8'he6);
        pulse_stop(1'b0);
        tick(4);
        chk("stop", 18'({stop_mode_out, det_run_out, det_reset_off_out}), 18'h7);
        chk("wd", wd_timeout_out, 18'h01ff0);
        chk("recovery", 18'(recovery_out), 18'h00020);
    endtask : t_opt1

    task automatic t_wake(input logic psel);
        int n;
        int t;
        t = (psel ? 512 : LCNT) * DIV;
        do_reset(1'b0);
        wr(CWU_ADDR_OPT1, {psel, 7'h02});
        wr(CWU_ADDR_KEN, 8'h40);
        rd(CWU_ADDR_KEN, 8'h40);
        // A stop cut short halfway must not shorten the next period.
        pulse_stop(1'b0);
        tick(t / 2);
        pulse_stop(1'b1);
        tick(4200);
        for (int k = 0; k < 2; k++) begin
            pulse_stop(1'b0);
            n = 0;
            while (irq_out !== 1'b1 && n < 40000) begin
                tick(1);
                n++;
            end
            chk("wake_time", 18'(n >= t && n <= t + 6), 18'h1);
            rd(CWU_ADDR_PORTA, 8'h40);
            rd(CWU_ADDR_KSC, 8'h08);
            chk("stop", 18'(stop_mode_out), 18'h0);
            wr(CWU_ADDR_KSC, 8'h04);
            rd(CWU_ADDR_PORTA, 8'h00);
            chk("irq", 18'(irq_out), 18'h0);
            tick(4200);
            rd(CWU_ADDR_PORTA, 8'h00);
        end
    endtask : t_wake

    task automatic t_mask();
        do_reset(1'b0);
        wr(CWU_ADDR_OPT1, 8'h06);
        wr(CWU_ADDR_KEN, 8'h40);
        wr(CWU_ADDR_KSC, 8'h02);
        pulse_stop(1'b0);
        tick(LCNT * DIV + 40);
        chk("masked", 18'({irq_out, stop_mode_out, det_run_out}), 18'h2);
        rd(CWU_ADDR_PORTA, 8'h40);
        wr(CWU_ADDR_KSC, 8'h00);
        rd(CWU_ADDR_KSC, 8'h08);
        chk("unmasked", 18'({irq_out, stop_mode_out}), 18'h2);
        wr(CWU_ADDR_KSC, 8'h04);
        wr(CWU_ADDR_KEN, 8'h00);
        tick(40);
        pulse_stop(1'b0);
        tick(LCNT * DIV + 40);
        rd(CWU_ADDR_PORTA, 8'h00);
        chk("held", 18'(stop_mode_out), 18'h1);
        pulse_stop(1'b1);
        tick(100);
        pulse_stop(1'b0);
        tick(4);
        chk("long_rec", 18'(stop_mode_out), 18'h0);
        tick(4100);
        pulse_stop(1'b0);
        tick(4);
        chk("rec_done", 18'(stop_mode_out), 18'h1);
    endtask : t_mask

    initial begin
        nrst_in     = 1'b0;
        por_in      = 1'b1;
        wr_in       = 1'b0;
        rd_in       = 1'b0;
        stop_req_in = 1'b0;
        lvi_rst_in  = 1'b0;
        addr_in     = 16'h0000;
        wdata_in    = 8'h00;
        t_reset_vals();
        t_clk_src();
        t_opt1();
        t_wake(1'b0);
        t_wake(1'b1);
        t_mask();
        tally_and_finish();
    end

    initial begin
        #500000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : cwu_top_tb
`default_nettype wire
